// ==== mms_seq.sv ====
`timescale 1ns/1ps

module mms_seq
    import mms_pkg::*;
#(
    parameter int unsigned INIT_WAIT   = INIT_MAX_CYC / 2,
    parameter int unsigned SERIAL_WAIT = SERIAL_MAX_CYC / 2,
    parameter int unsigned WAKE_WAIT   = WAKE_MAX_CYC / 2
) (
    // Clock and power-on reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // Host pins
    input  wire logic              active_low_reset_pin_i,
    input  wire logic              low_power_select_pin_i,
    // Monitored conditions, per lane
    input  wire logic [LANES-1:0]  rx_los_i,
    input  wire logic [LANES-1:0]  tx_fault_i,
    input  wire logic [LANES-1:0]  other_cond_i,
    // Host register side, same clock
    input  wire logic [FLAG_W-1:0] flag_clear_i,
    input  wire logic              ready_clear_i,
    input  wire logic [FLAG_W-1:0] flag_mask_i,
    input  wire logic              sw_power_down_i,
    input  wire logic [RATE_W-1:0] rate_select_i,
    // Status and pins out
    output logic                   active_low_interrupt_line_o,
    output logic                   serial_ready_o,
    output logic                   data_not_ready_o,
    output logic                   fully_functional_o,
    output logic                   power_level1_o,
    output logic [FLAG_W-1:0]      flags_o,
    output logic [RATE_W-1:0]      rate_applied_o,
    output logic                   rate_conform_o
);

    // ================================================
    // State record
    typedef struct packed {
        logic [SYNC_W-1:0]     s1;
        logic [SYNC_W-1:0]     s2;
        logic [SYNC_W-1:0]     s3;
        logic [SYNC_W-1:0]     filt;
        mms_state_e            state;
        logic [CNT_W-1:0]      cnt;
        logic [CNT_W-1:0]      ser_cnt;
        logic                  ser_rdy;
        logic [RST_CNT_W-1:0]  rst_lo_cnt;
        logic                  dnr;
        logic                  ready_pend;
        logic [FLAG_W-1:0]     flags;
        logic                  int_n;
        logic                  lp1;
        logic                  func;
        logic [RATE_W-1:0]     rate;
        logic [RATE_CNT_W-1:0] rate_cnt;
        logic                  conform;
    } mms_state_s;

    mms_state_s q;
    mms_state_s d;

    // ================================================
    // Derived terms
    logic [SYNC_W-1:0] filt_d;
    logic              rst_low;
    logic              rst_req;
    logic              lp_req;
    logic              flag_en;
    logic [FLAG_W-1:0] cond_now;
    logic [FLAG_W-1:0] flag_set;

    // Input held until two late stages agree
    assign filt_d = (q.s2 & q.s3) | (q.filt & (q.s2 | q.s3));

    // Reset pin counts only after the glitch filter
    assign rst_low = ~q.filt[SYNC_RST_BIT];
    // Request in the last cycle of the minimum low time, so a pulse of exactly that width counts
    assign rst_req = rst_low && (q.rst_lo_cnt == RST_CNT_W'(RST_MIN_CYC - 1));

    // Low power by pin or by software bit
    assign lp_req = filt_d[SYNC_LP_BIT] | sw_power_down_i;

    // Conditions flag only once initialised
    assign flag_en  = (q.state != ST_INIT) && (q.state != ST_HELD);
    assign cond_now = filt_d[SYNC_COND_LSB +: FLAG_W];
    assign flag_set = cond_now & ~q.filt[SYNC_COND_LSB +: FLAG_W]
                      & {FLAG_W{flag_en}};

    // ================================================
    // Next-state logic
    always_comb begin
        d = q;

        // Three-stage pin synchroniser
        d.s1   = {other_cond_i, tx_fault_i, rx_los_i,
                  low_power_select_pin_i, active_low_reset_pin_i};
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.filt = filt_d;

        // Low-time counter of the reset pin
        if (!rst_low) begin
            d.rst_lo_cnt = '0;
        end else if (q.rst_lo_cnt != RST_CNT_W'(RST_MIN_CYC - 1)) begin
            d.rst_lo_cnt = q.rst_lo_cnt + 1'b1;
        end

        // Serial bus comes alive after power-on only
        if (!q.ser_rdy) begin
            if (q.ser_cnt == CNT_W'(SERIAL_WAIT - 1)) begin
                d.ser_rdy = 1'b1;
            end else begin
                d.ser_cnt = q.ser_cnt + 1'b1;
            end
        end

        // Power sequencing
        case (q.state)
            ST_INIT: begin
                d.dnr  = 1'b1;
                d.func = 1'b0;
                d.cnt  = q.cnt + 1'b1;
                if (q.cnt == CNT_W'(INIT_WAIT - 1)) begin
                    d.state      = ST_RUN;
                    d.cnt        = '0;
                    d.dnr        = 1'b0;
                    d.ready_pend = 1'b1;
                    d.func       = 1'b1;
                end
            end
            ST_HELD: begin
                d.dnr        = 1'b1;
                d.func       = 1'b0;
                d.ready_pend = 1'b0;
                d.flags      = '0;
                if (!rst_low) begin
                    d.state = ST_INIT;
                    d.cnt   = '0;
                end
            end
            ST_RUN: begin
                if (lp_req) begin
                    d.state = ST_LOWPWR;
                    d.lp1   = 1'b1;
                    d.func  = 1'b0;
                end
            end
            ST_LOWPWR: begin
                d.lp1 = 1'b1;
                if (!lp_req) begin
                    d.state = ST_WAKE;
                    d.lp1   = 1'b0;
                    d.cnt   = '0;
                end
            end
            ST_WAKE: begin
                d.cnt = q.cnt + 1'b1;
                if (lp_req) begin
                    d.state = ST_LOWPWR;
                    d.lp1   = 1'b1;
                end else if (q.cnt == CNT_W'(WAKE_WAIT - 1)) begin
                    d.state = ST_RUN;
                    d.func  = 1'b1;
                    d.cnt   = '0;
                end
            end
            default: begin
                d.state = ST_INIT;
                d.cnt   = '0;
            end
        endcase

        // Valid reset request wins in any state
        if (rst_req) begin
            d.state      = ST_HELD;
            d.dnr        = 1'b1;
            d.func       = 1'b0;
            d.lp1        = 1'b0;
            d.ready_pend = 1'b0;
            d.flags      = '0;
            d.cnt        = '0;
        end

        // Sticky flags: a set beats a clearing read, a pin reset beats both
        if (flag_en && !rst_req) begin
            d.flags = (q.flags & ~flag_clear_i) | flag_set;
        end

        // Readiness event cleared by its read; its set during init wins
        if (ready_clear_i && (q.state != ST_INIT)) begin
            d.ready_pend = 1'b0;
        end

        // Interrupt line low while any event is unmasked
        d.int_n = ~(d.ready_pend | (|(d.flags & ~flag_mask_i)));

        // Rate select change then settle period
        if (rate_select_i != q.rate) begin
            d.rate     = rate_select_i;
            d.conform  = 1'b0;
            d.rate_cnt = '0;
        end else if (!q.conform) begin
            d.rate_cnt = q.rate_cnt + 1'b1;
            if (q.rate_cnt == RATE_CNT_W'(RATE_SETTLE_CYC - 1)) begin
                d.conform = 1'b1;
            end
        end
    end

    // ================================================
    // State register
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            q       <= '0;
            q.s1    <= SYNC_RST_VAL;
            q.s2    <= SYNC_RST_VAL;
            q.s3    <= SYNC_RST_VAL;
            q.filt  <= SYNC_RST_VAL;
            q.state <= ST_INIT;
            q.dnr   <= DNR_RST;
            q.int_n <= INT_N_RST;
        end else begin
            q <= d;
        end
    end

    // ================================================
    // Outputs, all straight from the record
    assign active_low_interrupt_line_o = q.int_n;
    assign serial_ready_o              = q.ser_rdy;
    assign data_not_ready_o            = q.dnr;
    assign fully_functional_o          = q.func;
    assign power_level1_o              = q.lp1;
    assign flags_o                     = q.flags;
    assign rate_applied_o              = q.rate;
    assign rate_conform_o              = q.conform;

    // ================================================
    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);

    // Reset entered only after full low time
    rst_filter_a: assert property (
        (q.state == ST_HELD) && ($past(q.state) != ST_HELD)
        |-> $past(q.rst_lo_cnt) == RST_CNT_W'(RST_MIN_CYC - 1))
        else $error("reset taken before minimum low time");

    // Pin reset drops flags, events and function
    held_clear_a: assert property (
        (q.state == ST_HELD) |-> (q.flags == '0) && !q.ready_pend && !q.func)
        else $error("state kept through pin reset");

    // Serial ready exactly at its count
    serial_ready_a: assert property (
        !q.ser_rdy ##1 q.ser_rdy
        |-> $past(q.ser_cnt) == CNT_W'(SERIAL_WAIT - 1))
        else $error("serial ready at wrong count");

    // Serial ready stands once given
    serial_hold_a: assert property (
        q.ser_rdy |=> q.ser_rdy)
        else $error("serial ready dropped");

    // Interrupt joins not-ready release
    ready_int_a: assert property (
        $fell(q.dnr) |-> !q.int_n && q.func)
        else $error("not-ready cleared without interrupt");

    // Not-ready held while starting up
    dnr_hold_a: assert property (
        (q.state == ST_INIT) || (q.state == ST_HELD) |-> q.dnr)
        else $error("not-ready dropped during init");

    // Init completes at its count
    init_done_a: assert property (
        (q.state == ST_INIT) && !rst_req
        && (q.cnt == CNT_W'(INIT_WAIT - 1))
        |=> !q.dnr && q.func && (q.state == ST_RUN))
        else $error("init did not complete on time");

    // Low-power request takes effect next cycle
    lp_entry_a: assert property (
        (q.state == ST_RUN) && lp_req && !rst_req
        |=> q.lp1 && !q.func)
        else $error("low power not entered");

    // Low power state keeps power level one
    lowpwr_hold_a: assert property (
        (q.state == ST_LOWPWR) |-> q.lp1 && !q.func)
        else $error("low power state without power level one");

    // Wake completes at its count
    wake_done_a: assert property (
        (q.state == ST_WAKE) && !lp_req && !rst_req
        && (q.cnt == CNT_W'(WAKE_WAIT - 1))
        |=> q.func && !q.lp1)
        else $error("wake did not complete on time");

    // Line follows unmasked events
    int_track_a: assert property (
        1'b1 |=> q.int_n == !(q.ready_pend
        || (|(q.flags & ~$past(flag_mask_i)))))
        else $error("interrupt line mismatch");

    // Condition edge sets its flag
    flag_set_a: assert property (
        (|flag_set) && !rst_req
        |=> (q.flags & $past(flag_set)) == $past(flag_set))
        else $error("flag not set by condition");

    // Clearing read clears flag
    flag_clear_a: assert property (
        |(flag_clear_i & ~flag_set & q.flags)
        |=> (q.flags & $past(flag_clear_i & ~flag_set)) == '0)
        else $error("flag not cleared by read");

    // Conform rises only at the settle count, with the rate unchanged
    rate_settle_a: assert property (
        $rose(q.conform)
        |-> $past(q.rate_cnt) == RATE_CNT_W'(RATE_SETTLE_CYC - 1)
        && $stable(q.rate))
        else $error("rate settled at wrong count");

endmodule // mms_seq

// ==== mms_pkg.sv ====
// ====================================================
// Shared constants of the management sequencer
package mms_pkg;

    // ================================================
    // Clock rate
    localparam int CLK_KHZ = 25000;

    // ================================================
    // Times in their own units (all maxima except reset)
    localparam int T_RST_MIN_US = 2;
    localparam int T_INIT_MS    = 2000;
    localparam int T_SERIAL_MS  = 2000;
    localparam int T_WAKE_MS    = 300;
    localparam int T_RATE_US    = 100;

    // ================================================
    // Cycle counts derived from the times
    localparam int RST_MIN_CYC     = (T_RST_MIN_US * CLK_KHZ + 999) / 1000;
    localparam int INIT_MAX_CYC    = T_INIT_MS * CLK_KHZ;
    localparam int SERIAL_MAX_CYC  = T_SERIAL_MS * CLK_KHZ;
    localparam int WAKE_MAX_CYC    = T_WAKE_MS * CLK_KHZ;
    localparam int RATE_MAX_CYC    = (T_RATE_US * CLK_KHZ) / 1000;
    localparam int RATE_SETTLE_CYC = RATE_MAX_CYC / 2;

    // ================================================
    // Widths
    localparam int CNT_W      = 26;
    localparam int RST_CNT_W  = 6;
    localparam int RATE_CNT_W = 12;
    localparam int RATE_W     = 8;
    localparam int LANES      = 4;
    localparam int FLAG_W     = 3 * LANES;

    // ================================================
    // Flag layout
    localparam int FLAG_LOS_LSB = 0;
    localparam int FLAG_TXF_LSB = 4;
    localparam int FLAG_OTH_LSB = 8;

    // ================================================
    // Synchroniser vector layout
    localparam int SYNC_RST_BIT  = 0;
    localparam int SYNC_LP_BIT   = 1;
    localparam int SYNC_COND_LSB = 2;
    localparam int SYNC_W        = SYNC_COND_LSB + FLAG_W;

    // ================================================
    // Reset values
    localparam logic [SYNC_W-1:0] SYNC_RST_VAL = 14'h0001;
    localparam logic              DNR_RST      = 1'b1;
    localparam logic              INT_N_RST    = 1'b1;

    // ================================================
    // Sequencer states
    typedef enum logic [2:0] {
        ST_INIT   = 3'b000,
        ST_HELD   = 3'b001,
        ST_RUN    = 3'b010,
        ST_LOWPWR = 3'b011,
        ST_WAKE   = 3'b100
    } mms_state_e;

endpackage

// ==== mms_host_model.sv ====
`timescale 1ns/1ps

// ================================================
// Host controller model: reset pin and read-clear pulses
module mms_host_model
    import mms_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // Commands from the bench
    input  wire logic              rst_go_i,
    input  wire logic [7:0]        rst_len_i,
    input  wire logic              rd_go_i,
    input  wire logic [FLAG_W-1:0] rd_sel_i,
    input  wire logic              rd_rdy_i,
    // Pins and read completions
    output logic                   active_low_reset_pin_o,
    output logic [FLAG_W-1:0]      flag_clear_o,
    output logic                   ready_clear_o
);
    logic [7:0] low_cnt_q;

    // Pin held low for the commanded span
    assign active_low_reset_pin_o = (low_cnt_q == 8'h00);

    // Pulse width counter and read completion pulses
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            low_cnt_q     <= 8'h00;
            flag_clear_o  <= '0;
            ready_clear_o <= 1'b0;
        end else begin
            if (rst_go_i) begin
                low_cnt_q <= rst_len_i;
            end else if (low_cnt_q != 8'h00) begin
                low_cnt_q <= low_cnt_q - 8'h01;
            end
            flag_clear_o  <= rd_go_i ? rd_sel_i : '0;
            ready_clear_o <= rd_go_i & rd_rdy_i;
        end
    end
endmodule // mms_host_model

// ==== mms_seq_tb.sv ====
`timescale 1ns/1ps

// ================================================
// Bench for the management sequencer
module mms_seq_tb;
    import mms_pkg::*;
    localparam int IW = 100;
    localparam int SW = 80;
    localparam int WW = 50;
    logic              clk_sys_i, reset_i, lp_pin, sw_pd, rst_go, rd_go, rd_rdy;
    logic              pin_n, rclr, int_n, sready, dnr, ff, pl1, rconf;
    logic [FLAG_W-1:0] cond, mask, rd_sel, fclr, flags;
    logic [RATE_W-1:0] rsel, rapp;
    logic [7:0]        rst_len;
    int                fails, checked;

    // ================================================
    // Instances
    mms_seq #(.INIT_WAIT(IW), .SERIAL_WAIT(SW), .WAKE_WAIT(WW)) mms_seq_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .active_low_reset_pin_i(pin_n),
        .low_power_select_pin_i(lp_pin), .rx_los_i(cond[3:0]), .tx_fault_i(cond[7:4]),
        .other_cond_i(cond[11:8]), .flag_clear_i(fclr), .ready_clear_i(rclr),
        .flag_mask_i(mask), .sw_power_down_i(sw_pd), .rate_select_i(rsel),
        .active_low_interrupt_line_o(int_n), .serial_ready_o(sready), .data_not_ready_o(dnr),
        .fully_functional_o(ff), .power_level1_o(pl1), .flags_o(flags),
        .rate_applied_o(rapp), .rate_conform_o(rconf));
    mms_host_model mms_host_model_i (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .rst_go_i(rst_go), .rst_len_i(rst_len),
        .rd_go_i(rd_go), .rd_sel_i(rd_sel), .rd_rdy_i(rd_rdy), .active_low_reset_pin_o(pin_n),
        .flag_clear_o(fclr), .ready_clear_o(rclr));

    // ================================================
    // Helpers
    task tick(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task half;
        @(negedge clk_sys_i);
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task host_read(input logic [11:0] sel, input logic rdy);
        tick(1);
        rd_sel <= sel;
        rd_rdy <= rdy;
        rd_go  <= 1'b1;
        tick(1);
        rd_go  <= 1'b0;
        tick(3);
        half;
    endtask
    task conclude;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ================================================
    // Scenarios
    task t_init;
        tick(SW - 5);
        half;
        chk(sready, 1'b0);
        chk(dnr, 1'b1);
        tick(10);
        half;
        chk(sready, 1'b1);
        tick(IW - SW);
        half;
        chk({dnr, ff, int_n}, 3'b010);
        host_read(12'h000, 1'b1);
        chk(int_n, 1'b1);
        $display("test init done");
    endtask
    task t_flags;
        logic [11:0] b;
        for (int g = 0; g < 3; g++) begin
            b = 12'h001 << (5 * g + 1);
            tick(1);
            cond <= b;
            tick(8);
            cond <= '0;
            half;
            chk(flags, b);
            chk(int_n, 1'b0);
            host_read(b, 1'b0);
            chk({flags, int_n}, 13'h0001);
        end
        tick(1);
        cond <= 12'h011;
        tick(8);
        cond <= '0;
        host_read(12'h001, 1'b0);
        chk({flags, int_n}, 13'h0020);
        host_read(12'h010, 1'b0);
        chk(int_n, 1'b1);
        $display("test flags done");
    endtask
    task t_mask;
        tick(1);
        mask <= 12'h400;
        cond <= 12'h400;
        tick(8);
        cond <= '0;
        half;
        chk({flags, int_n}, 13'h0801);
        tick(1);
        mask <= '0;
        tick(2);
        half;
        chk(int_n, 1'b0);
        tick(1);
        mask <= 12'h400;
        tick(2);
        half;
        chk(int_n, 1'b1);
        tick(1);
        mask <= '0;
        tick(2);
        half;
        chk(int_n, 1'b0);
        host_read(12'h400, 1'b0);
        chk(int_n, 1'b1);
        $display("test mask done");
    endtask
    task t_power(input logic by_pin);
        tick(1);
        if (by_pin) lp_pin <= 1'b1;
        else sw_pd <= 1'b1;
        tick(8);
        half;
        chk({pl1, ff}, 2'b10);
        tick(1);
        if (by_pin) lp_pin <= 1'b0;
        else sw_pd <= 1'b0;
        tick(8);
        half;
        chk({pl1, ff}, 2'b00);
        tick(WW);
        half;
        chk({pl1, ff}, 2'b01);
        $display("test power done");
    endtask
    task t_rate;
        tick(RATE_SETTLE_CYC);
        half;
        chk(rconf, 1'b1);
        tick(1);
        rsel <= 8'h5a;
        tick(2);
        half;
        chk({rapp, rconf}, {8'h5a, 1'b0});
        tick(RATE_SETTLE_CYC - 4);
        half;
        chk(rconf, 1'b0);
        tick(4);
        half;
        chk(rconf, 1'b1);
        $display("test rate done");
    endtask
    task t_pin;
        tick(1);
        rst_len <= 8'(RST_MIN_CYC - 1);
        rst_go <= 1'b1;
        tick(1);
        rst_go <= 1'b0;
        tick(RST_MIN_CYC + 10);
        half;
        chk({dnr, ff}, 2'b01);
        tick(1);
        rst_len <= 8'(RST_MIN_CYC);
        rst_go <= 1'b1;
        tick(1);
        rst_go <= 1'b0;
        tick(RST_MIN_CYC + 10);
        half;
        chk({dnr, ff}, 2'b10);
        tick(IW);
        half;
        chk({dnr, ff, int_n}, 3'b010);
        $display("test pin reset done");
    endtask

    // ================================================
    // Clock, watchdog and main sequence
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (6000) @(posedge clk_sys_i);
        fails++;
        conclude;
    end
    initial begin
        {lp_pin, sw_pd, rst_go, rd_go, rd_rdy} = 5'h00;
        {cond, mask, rd_sel, rsel, rst_len} = '0;
        fails = 0;
        checked = 0;
        reset_i = 1'b1;
        tick(5);
        reset_i <= 1'b0;
        t_init;
        t_flags;
        t_mask;
        t_power(1'b1);
        t_power(1'b0);
        t_rate;
        t_pin;
        conclude;
    end
endmodule // mms_seq_tb
